// ===== tct_pkg.sv
package tct_pkg;

	// ****************************************************************
	// Widths and field positions
	// ****************************************************************
	localparam int TEMP_W     = 8;
	localparam int CTRL_W     = 5;
	localparam int DUTY_LSB   = 1;
	localparam int DUTY_MSB   = 3;
	localparam int OD_EN_BIT  = 4;
	localparam int DUTY_W     = 3;
	localparam int EIGHTHS    = 8;

	// ****************************************************************
	// Hard-wired thresholds (degrees C, raw sensor code) and duty/control constants
	// ****************************************************************
	localparam logic [TEMP_W-1:0] TRIP_TEMP   = 8'h64;
	localparam logic [TEMP_W-1:0] HYST_DROP   = 8'h02;
	localparam logic [TEMP_W-1:0] CATAST_TEMP = 8'h7d;
	localparam logic [DUTY_W-1:0] AUTO_DUTY   = 3'h4;
	localparam logic [DUTY_W-1:0] DUTY_RSVD   = 3'h0;
	localparam logic [CTRL_W-1:0] CTRL_RESET  = 5'h00;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_AUTO,
		ST_DEMAND
	} tct_mode_t;

	typedef enum logic [1:0] {
		PW_RUN,
		PW_STOPGRANT,
		PW_SLEEP,
		PW_DEEPSLEEP
	} tct_power_t;

	typedef struct packed {
		logic             autoEnable;
		logic [CTRL_W-1:0] ctrl;
	} tct_cfg_t;

	typedef struct packed {
		logic throttleActive;
		logic clockRun;
		logic irqService;
	} tct_stat_t;

endpackage

// ===== tct_modulator.sv
`timescale 1ns/1ps

module tct_modulator #(
	parameter int unsigned SLOT_CYCLES = 4
) (
	input  wire logic                        mclk,
	input  wire logic                        nrst,
	input  wire logic                        active,
	input  wire logic [tct_pkg::DUTY_W-1:0]  duty,
	output logic                             clockRun
);
	import tct_pkg::*;

	localparam int SW = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;

	typedef struct packed {
		logic [SW-1:0]     slotCnt;
		logic [DUTY_W-1:0] eighth;
		logic              run;
	} tct_mod_state_t;

	tct_mod_state_t state_q;
	tct_mod_state_t state_d;

	// ****************************************************************
	// Period = 8 slots of SLOT_CYCLES core clocks, so it scales with mclk
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		if (!active) begin
			state_d.slotCnt = '0;
			state_d.eighth  = '0;
			state_d.run     = 1'b1;
		end else begin
			if (state_q.slotCnt == SW'(SLOT_CYCLES - 1)) begin // [R3]
				state_d.slotCnt = '0;
				state_d.eighth  = state_q.eighth + 3'h1;
			end else begin
				state_d.slotCnt = state_q.slotCnt + SW'(1);
			end
			// Clocks run in eighths below the duty value; registered so
			// the gate only changes on a clock boundary
			state_d.run = (state_d.eighth < duty); // [R19] [R20]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= '{slotCnt: '0, eighth: '0, run: 1'b1};
		end else begin
			state_q <= state_d;
		end
	end

	assign clockRun = state_q.run;

endmodule

// ===== thermal_clock_throttle.sv
`timescale 1ns/1ps

// Operation
// [R1] Auto mode throttles only when die reaches trip temperature.
// [R2] Auto throttle uses fixed 50% clock on-time, not software alterable.
// [R3] Modulation period is a fixed count of core clocks.
// [R4] Throttle stops once temperature falls to non-critical level.
// [R5] Hysteresis separates activation and deactivation thresholds.
// [R6] Trip temperature is hardwired and not visible to software.
// [R7] Control bit 4 set activates throttle immediately, any temperature.
// [R8] On-demand on-time taken from control bits 3:1 in eighths.
// [R9] Auto modulation overrides on-demand duty when hot with auto enabled.
// [R10] Snooping continues; interrupts latched and serviced only in clock-on time.
// [R11] Hot output, active low, asserts while die is above trip point.
// [R12] Hot output not newly asserted in stop-grant, sleep, deep sleep.
// [R13] Hot held through low-power state until exit and temperature drops.
// [R14] Catastrophic output asserts near 125 C regardless of mode enables.
// [R15] Catastrophic trip independent of activity, makes no bus cycle.
// [R16] Platform must remove core supply after catastrophic trip.
// [R17] Firmware must enable auto mode via configuration registers.
// [R18] Auto throttling runs entirely in hardware.
// [R19] Duty k in 1..7 gives k eighths running; zero is reserved.
// [R20] Clock gating changes only on core clock boundaries.
module thermal_clock_throttle #(
	parameter int unsigned SLOT_CYCLES = 4
) (
	input  wire logic                         mclk,
	input  wire logic                         nrst,
	input  wire logic [tct_pkg::TEMP_W-1:0]   dieTemp,
	input  tct_pkg::tct_cfg_t                 cfg,
	input  tct_pkg::tct_power_t               powerState,
	input  wire logic                         irqIn,
	input  wire logic                         snoopReq,
	output logic                              coreClkEn,
	output logic                              irqToCore,
	output logic                              snoopAck,
	output logic                              die_hot_alert_n,
	output logic                              catastrophic_overheat_n,
	output tct_pkg::tct_stat_t                status
);
	import tct_pkg::*;

	typedef struct packed {
		logic      hot;
		logic      alertHot;
		logic      tripped;
		logic      irqPending;
		logic      irqOut;
		logic      snoopOut;
		tct_mode_t mode;
	} tct_state_t;

	tct_state_t        state_q;
	tct_state_t        state_d;
	logic              clockRun;
	logic [DUTY_W-1:0] activeDuty;
	logic              odRequest;
	logic              lowPower;
	logic              odDutyOk;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic aboveTrip(input logic [TEMP_W-1:0] t);
		return t >= TRIP_TEMP;
	endfunction

	function automatic logic belowRelease(input logic [TEMP_W-1:0] t);
		return t < (TRIP_TEMP - HYST_DROP);
	endfunction

	function automatic logic [DUTY_W-1:0] dutyField(input logic [CTRL_W-1:0] c);
		return c[DUTY_MSB:DUTY_LSB];
	endfunction

	// Reserved duty of zero keeps clocks running rather than stopping the core
	assign odDutyOk  = (dutyField(cfg.ctrl) != DUTY_RSVD); // [R19]
	assign odRequest = cfg.ctrl[OD_EN_BIT] && odDutyOk; // [R7]
	assign lowPower  = (powerState != PW_RUN);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_d = state_q;

		// Threshold never leaves the block; nothing reads or writes it
		if (!state_q.hot && aboveTrip(dieTemp)) begin // [R1] [R6]
			state_d.hot = 1'b1;
		end else if (state_q.hot && belowRelease(dieTemp)) begin // [R4] [R5]
			state_d.hot = 1'b0;
		end

		// Mode arbitration: auto wins over on-demand when hot
		if (cfg.autoEnable && state_d.hot) begin // [R9] [R18]
			state_d.mode = ST_AUTO;
		end else if (odRequest) begin // [R7]
			state_d.mode = ST_DEMAND;
		end else begin
			state_d.mode = ST_IDLE; // [R4]
		end

		// Hot alert: sensed above trip point, frozen while powerState is not PW_RUN
		if (!lowPower) begin
			state_d.alertHot = aboveTrip(dieTemp); // [R11]
		end else if (state_q.alertHot) begin
			state_d.alertHot = 1'b1; // [R13]
		end else begin
			state_d.alertHot = 1'b0; // [R12]
		end

		// Catastrophic trip sticks until reset; needs no mode or activity
		if (dieTemp >= CATAST_TEMP) begin // [R14] [R15]
			state_d.tripped = 1'b1;
		end

		// Interrupts wait for a clock-on slot; a new one wins over a clear
		state_d.irqOut = 1'b0;
		if (state_q.irqPending && coreClkEn) begin // [R10]
			state_d.irqOut     = 1'b1;
			state_d.irqPending = 1'b0;
		end
		if (irqIn) begin
			state_d.irqPending = 1'b1; // [R10]
		end

		// Snoops are answered regardless of throttle state
		state_d.snoopOut = snoopReq; // [R10]
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= '{hot: 1'b0, alertHot: 1'b0, tripped: 1'b0,
				irqPending: 1'b0, irqOut: 1'b0, snoopOut: 1'b0, mode: ST_IDLE};
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************************************
	// Clock modulation
	// ****************************************************************
	always_comb begin
		if (state_q.mode == ST_AUTO) begin
			activeDuty = AUTO_DUTY; // [R2]
		end else begin
			activeDuty = dutyField(cfg.ctrl); // [R8]
		end
	end

	tct_modulator #(
		.SLOT_CYCLES (SLOT_CYCLES)
	) u_mod (
		.mclk     (mclk),
		.nrst     (nrst),
		.active   (state_q.mode != ST_IDLE),
		.duty     (activeDuty),
		.clockRun (clockRun)
	);

	// Gate from a flop so enable changes align with mclk edges
	assign coreClkEn = clockRun && !state_q.tripped; // [R20] [R14]

	assign irqToCore               = state_q.irqOut;
	assign snoopAck                = state_q.snoopOut;
	assign die_hot_alert_n         = !state_q.alertHot; // [R11]
	assign catastrophic_overheat_n = !state_q.tripped; // [R14]

	// One driver for the whole packed struct
	assign status = '{throttleActive: (state_q.mode != ST_IDLE),
		clockRun: coreClkEn,
		irqService: state_q.irqPending};

endmodule

// ===== tct_assertions.sv
`timescale 1ns/1ps
module tct_assertions #(
	parameter int unsigned SLOT_CYCLES = 4
) (
	input wire logic                       mclk,
	input wire logic                       nrst,
	input wire logic [tct_pkg::TEMP_W-1:0] dieTemp,
	input tct_pkg::tct_cfg_t               cfg,
	input tct_pkg::tct_power_t             powerState,
	input wire logic                       coreClkEn,
	input wire logic                       irqToCore,
	input wire logic                       die_hot_alert_n,
	input wire logic                       catastrophic_overheat_n
);
	import tct_pkg::*;
	int offCnt_q;
	// Clock-off stretch length, read at each restart of the clock
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			offCnt_q <= 0;
		end else begin
			offCnt_q <= coreClkEn ? 0 : offCnt_q + 1;
		end
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_trip_cause: assert property (
		dieTemp >= CATAST_TEMP |=> !catastrophic_overheat_n) else $error("trip late");
	a_trip_sticky: assert property (
		!catastrophic_overheat_n |=> !catastrophic_overheat_n) else $error("trip released");
	a_hot_cause: assert property (
		(dieTemp >= TRIP_TEMP && powerState == PW_RUN)[*3] |=> !die_hot_alert_n)
		else $error("hot late");
	a_hot_no_new: assert property (
		powerState != PW_RUN && $past(powerState) != PW_RUN && die_hot_alert_n
		|=> die_hot_alert_n) else $error("hot in low power");
	a_hot_hold: assert property (
		powerState != PW_RUN && !die_hot_alert_n |=> !die_hot_alert_n)
		else $error("hot dropped");
	a_auto_off: assert property (
		$rose(coreClkEn) && cfg.autoEnable && dieTemp >= TRIP_TEMP
		|-> offCnt_q == 4 * SLOT_CYCLES) else $error("auto off time");
	a_demand_off: assert property (
		$rose(coreClkEn) && !cfg.autoEnable && cfg.ctrl[OD_EN_BIT]
		&& cfg.ctrl[DUTY_MSB:DUTY_LSB] != DUTY_RSVD
		|-> offCnt_q == (EIGHTHS - cfg.ctrl[DUTY_MSB:DUTY_LSB]) * SLOT_CYCLES)
		else $error("demand off time");
	a_irq_gated: assert property (
		irqToCore |-> $past(coreClkEn)) else $error("irq while stopped");
endmodule

bind thermal_clock_throttle tct_assertions #(.SLOT_CYCLES(SLOT_CYCLES)) chk (
	.mclk(mclk), .nrst(nrst), .dieTemp(dieTemp), .cfg(cfg), .powerState(powerState),
	.coreClkEn(coreClkEn), .irqToCore(irqToCore), .die_hot_alert_n(die_hot_alert_n),
	.catastrophic_overheat_n(catastrophic_overheat_n));

// ===== tct_platform.sv
`timescale 1ns/1ps
module tct_platform (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic autoReq,
	input  wire logic catastrophic_overheat_n,
	output logic      autoEnable,
	output logic      supplyOn
);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			autoEnable <= 1'b0;
			supplyOn <= 1'b1;
		end else begin
			autoEnable <= autoReq;
			// Supply cut is latched: the core stays dead until reset
			if (!catastrophic_overheat_n) begin
				supplyOn <= 1'b0;
			end
		end
	end
endmodule

// ===== thermal_clock_throttle_bench.sv
`timescale 1ns/1ps
module thermal_clock_throttle_bench;
	import tct_pkg::*;
	localparam int unsigned SLOT = 4;
	logic mclk = 0, nrst = 0, irqIn = 0, snoopReq = 0, autoReq = 0, go = 0;
	logic coreClkEn, hotN, tripN, autoEn, supplyOn, irqToCore, snoopAck;
	logic irqPend = 0, irqExp = 0, snoopExp = 0;
	logic [TEMP_W-1:0] dieTemp = 8'h19;
	logic [CTRL_W-1:0] ctrl = CTRL_RESET;
	logic [31:0] rng = 32'h3cdf;
	tct_power_t powerState = PW_RUN;
	tct_cfg_t cfg;
	tct_stat_t status;
	int fails = 0, cmp_count = 0, offCnt = 0, expQ[$];
	assign cfg = {autoEn, ctrl};
	always #25 mclk = ~mclk;
	thermal_clock_throttle #(.SLOT_CYCLES(SLOT)) uut (.mclk(mclk), .nrst(nrst),
		.dieTemp(dieTemp), .cfg(cfg), .powerState(powerState), .irqIn(irqIn),
		.snoopReq(snoopReq), .coreClkEn(coreClkEn), .irqToCore(irqToCore),
		.snoopAck(snoopAck),
		.die_hot_alert_n(hotN), .catastrophic_overheat_n(tripN), .status(status));
	tct_platform plat (.mclk(mclk), .nrst(nrst), .autoReq(autoReq),
		.catastrophic_overheat_n(tripN), .autoEnable(autoEn), .supplyOn(supplyOn));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		fails += expQ.size();
		if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	always @(posedge mclk) begin
		#1;
		if (go) begin
			rng = xs(rng);
			irqIn = rng[0];
			snoopReq = rng[1];
		end
	end
	// Each clock-off stretch in a steady mode is matched to the oldest note;
	// sampled mid-cycle so the gate flop has settled
	always @(negedge mclk) begin
		if (!coreClkEn) offCnt++;
		else if (offCnt > 0) begin
			if ((autoEn && dieTemp >= TRIP_TEMP) || (!autoEn && ctrl[OD_EN_BIT]))
				check(8'(offCnt), expQ.size() ? 8'(expQ.pop_front()) : 8'hff);
			offCnt = 0;
		end
	end
	// Interrupts wait for a clock-on cycle; snoops answered a cycle later
	always @(negedge mclk) begin
		if (nrst) begin
			check({irqToCore, snoopAck, status.irqService, status.clockRun},
				{irqExp, snoopExp, irqPend, coreClkEn});
			irqExp = irqPend && coreClkEn;
			irqPend = (irqPend && !coreClkEn) || irqIn;
			snoopExp = snoopReq;
		end
	end
	initial begin
		repeat (2000) @(posedge mclk);
		fails++;
		complete_run();
	end
	initial begin
		step(8);
		nrst = 1;
		go = 1;
		step(2);
		for (int k = 1; k < 8; k++) begin
			ctrl = {1'b1, 3'(k), 1'b0};
			repeat (2) expQ.push_back((8 - k) * SLOT);
			step(70);
			ctrl = CTRL_RESET;
			step(40);
		end
		ctrl = 5'h11;
		step(5);
		check(status.throttleActive, 0);
		ctrl = CTRL_RESET;
		autoReq = 1;
		dieTemp = 8'h63;
		step(10);
		check(status.throttleActive, 0);
		dieTemp = TRIP_TEMP;
		step(5);
		ctrl = 5'h13;
		repeat (2) expQ.push_back(4 * SLOT);
		step(70);
		check(hotN, 0);
		ctrl = CTRL_RESET;
		dieTemp = 8'h62;
		step(10);
		check(status.throttleActive, 1);
		dieTemp = 8'h61;
		step(5);
		check({status.throttleActive, hotN}, 1);
		autoReq = 0;
		step(2);
		powerState = PW_SLEEP;
		dieTemp = 8'h6e;
		step(5);
		check(hotN, 1);
		powerState = PW_RUN;
		step(5);
		powerState = PW_DEEPSLEEP;
		dieTemp = 8'h19;
		step(5);
		check(hotN, 0);
		powerState = PW_RUN;
		step(5);
		check(hotN, 1);
		dieTemp = CATAST_TEMP;
		step(3);
		check({tripN, coreClkEn, supplyOn}, 0);
		dieTemp = 8'h19;
		step(5);
		check(tripN, 0);
		complete_run();
	end
endmodule
